// ==== hdl/stc_cfg.svh ====
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// Register offsets (word index on the plain register port)
`define STC_ADDR_CMD 4'h0
`define STC_ADDR_HOLDOFF 4'h1
`define STC_ADDR_PROGRESS_A_FIRED 4'h2
`define STC_ADDR_BTRIG 4'h3
`define STC_ADDR_BLEVEL 4'h4
`define STC_ADDR_TV 4'h5
`define STC_ADDR_VIDEO_LINE_NUMBER 4'h6
`define STC_ADDR_STATUS 4'h7
`define STC_ADDR_MINMAX 4'h8
`define STC_ADDR_EVENTS 4'h9

// Command register bits
`define STC_CMD_CLR_BIT 0
`define STC_CMD_AUTOLVL_BIT 1
`define STC_CMD_ASEC_BIT 2

// Holdoff: 0..100 with four fractional bits
`define STC_HOLDOFF_W 11
`define STC_HOLDOFF_MAX 11'h640
`define STC_HOLDOFF_RST 11'h000

// Level width (signed volts code)
`define STC_LVL_W 12

// Video line field
`define STC_VIDEO_LINE_NUMBER_W 10
`define STC_VIDEO_LINE_NUMBER_RST 10'h001
`define STC_VIDEO_LINE_NUMBER_MAX_F1 10'h107
`define STC_VIDEO_LINE_NUMBER_MAX_F2 10'h106

// Line counter start offset before field sync
`define STC_PRE_SYNC_LINES 10'h003

// Autolevel duration
`define STC_AUTOLVL_NS 1000
`define STC_CLK_NS 50
`define STC_AUTOLVL_CYC ((`STC_AUTOLVL_NS + `STC_CLK_NS - 1) / `STC_CLK_NS)

`endif

// ==== hdl/stc_line_counter.sv ====
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_line_counter import stc_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic sync_raw,
    input wire logic sync_positive,
    input wire logic field_sync,
    input wire logic field_is_two,
    input wire logic reset_first_field_only,
    input wire logic start_before_field_sync,
    input wire logic [`STC_VIDEO_LINE_NUMBER_W-1:0] target_line,
    input wire logic want_field_two,
    output logic line_hit
);
    logic sync_q;
    logic hit_q;
    logic [`STC_VIDEO_LINE_NUMBER_W-1:0] count_q;
    logic sync_pulse;
    logic sync_edge;
    logic do_reset;

    // Sync polarity relative to baseline
    assign sync_pulse = sync_positive ? sync_raw : ~sync_raw;
    assign sync_edge = sync_pulse & ~sync_q;
    assign do_reset = field_sync & (~field_is_two | ~reset_first_field_only);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_q <= 1'b0;
            count_q <= '0;
            hit_q <= 1'b0;
        end else begin
            sync_q <= sync_pulse;
            hit_q <= 1'b0;
            if (!enable) begin
                count_q <= '0;
            end else if (do_reset) begin
                count_q <= start_before_field_sync ? `STC_PRE_SYNC_LINES : '0;
            end else if (sync_edge) begin
                count_q <= count_q + 1'b1;
                hit_q <= (count_q + 1'b1 == target_line) && (field_is_two == want_field_two);
            end
        end
    end

    assign line_hit = hit_q;
endmodule : stc_line_counter

// ==== hdl/stc_pkg.sv ====
package stc_pkg;

    typedef enum logic [2:0] {
        STC_PROG_PROGRESS_A = 3'h0,
        STC_PROG_READY = 3'h1,
        STC_PROG_A_FIRED = 3'h2,
        STC_PROG_B_FIRED = 3'h3,
        STC_PROG_SAVED = 3'h4
    } stc_progress_t;

    typedef enum logic [1:0] {
        STC_FLD_ONE = 2'h0,
        STC_FLD_TWO = 2'h1,
        STC_FLD_ALT = 2'h2,
        STC_FLD_LINE = 2'h3
    } stc_field_t;

    typedef enum logic [1:0] {
        STC_AL_IDLE = 2'h0,
        STC_AL_MEASURE = 2'h1,
        STC_AL_DONE = 2'h2
    } stc_al_state_t;

endpackage : stc_pkg

// ==== hdl/stc_sync2.sv ====
`timescale 1ns/1ps
module stc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : stc_sync2

// ==== hdl/stc_top.sv ====
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_top import stc_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic hw_ready,
    input wire logic hw_a_fired,
    input wire logic hw_b_fired,
    input wire logic hw_saved,
    input wire logic [`STC_LVL_W-1:0] sig_level,
    input wire logic knob_step,
    input wire logic knob_up,
    input wire logic video_option_present,
    input wire logic word_probe_present,
    input wire logic video_interlaced,
    input wire logic video_sync,
    input wire logic video_field_sync,
    input wire logic video_field_two,
    input wire logic b_trigger_in,
    output logic [`STC_HOLDOFF_W-1:0] holdoff_setting,
    output logic [`STC_LVL_W-1:0] main_level,
    output logic [`STC_LVL_W-1:0] delayed_level,
    output logic status_show_delayed,
    output logic triggered_after_main,
    output logic b_sweep_go,
    output logic external_sample_clock,
    output logic sample_strobe,
    output logic back_porch_clamp,
    output logic video_line_trigger,
    output logic service_request,
    output logic [1:0] srq_cause
);
    typedef struct packed {
        logic [`STC_HOLDOFF_W-1:0] holdoff;
        logic knob_b;
        logic [`STC_LVL_W-1:0] a_level;
        logic [`STC_LVL_W-1:0] b_level;
        logic [2:0] b_source;
        logic [2:0] b_coupling;
        logic b_slope;
        logic [4:0] b_position;
        logic trig_after;
        logic ext_clk;
        stc_progress_t progress;
        stc_al_state_t al_state;
        logic [`STC_LVL_W-1:0] sig_min;
        logic [`STC_LVL_W-1:0] sig_max;
        logic [7:0] al_cnt;
        logic minmax_valid;
        stc_field_t interlaced_field_choice;
        logic nic_line;
        logic clamp;
        logic [`STC_VIDEO_LINE_NUMBER_W-1:0] video_line_number;
        logic lcnt_reset_first_field_only;
        logic lcnt_start_before_field_sync;
        logic sync_pos;
        logic tv_selected;
        logic warn_en;
        logic err_en;
        logic warn_flag;
        logic err_flag;
        logic b_progress_a;
        logic b_clk_q;
        logic [31:0] rdata;
    } stc_state_t;

    stc_state_t s_q;
    stc_state_t s_d;
    logic [5:0] pins_sync;
    logic line_hit;

    function automatic logic [`STC_LVL_W-1:0] stc_mid(
        input logic [`STC_LVL_W-1:0] a,
        input logic [`STC_LVL_W-1:0] b
    );
        logic [`STC_LVL_W:0] sum;
        sum = {a[`STC_LVL_W-1], a} + {b[`STC_LVL_W-1], b};
        return sum[`STC_LVL_W:1];
    endfunction : stc_mid

    function automatic logic [`STC_LVL_W-1:0] stc_step(
        input logic [`STC_LVL_W-1:0] lvl,
        input logic up
    );
        return up ? lvl + 1'b1 : lvl - 1'b1;
    endfunction : stc_step

    stc_sync2 #(.W(6)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({knob_step, knob_up, video_interlaced, video_sync,
                   video_field_sync, b_trigger_in}),
        .sync_out(pins_sync)
    );

    stc_line_counter u_lines (
        .clk(clk),
        .rst_b(rst_b),
        .enable(s_q.tv_selected & video_option_present),
        .sync_raw(pins_sync[2]),
        .sync_positive(s_q.sync_pos),
        .field_sync(pins_sync[1]),
        .field_is_two(video_field_two),
        .reset_first_field_only(s_q.lcnt_reset_first_field_only),
        .start_before_field_sync(s_q.lcnt_start_before_field_sync),
        .target_line(s_q.video_line_number),
        .want_field_two(pins_sync[3] ? (s_q.interlaced_field_choice != STC_FLD_ONE) : 1'b0),
        .line_hit(line_hit)
    );

    always_comb begin
        logic [`STC_VIDEO_LINE_NUMBER_W-1:0] maxline;
        maxline = '0;
        s_d = s_q;
        s_d.rdata = '0;
        s_d.b_clk_q = pins_sync[0];

        // Progress tracker moves only forward until the clear command returns it to STC_PROG_PROGRESS_A
        if (hw_saved && s_q.progress < STC_PROG_SAVED) begin
            s_d.progress = STC_PROG_SAVED;
        end else if (hw_b_fired && s_q.progress < STC_PROG_B_FIRED) begin
            s_d.progress = STC_PROG_B_FIRED;
        end else if (hw_a_fired && s_q.progress < STC_PROG_A_FIRED) begin
            s_d.progress = STC_PROG_A_FIRED;
        end else if (hw_ready && s_q.progress < STC_PROG_READY) begin
            s_d.progress = STC_PROG_READY;
        end

        // Knob adjusts the selected trigger level
        if (pins_sync[5]) begin
            if (s_q.knob_b) begin
                s_d.b_level = stc_step(s_q.b_level, pins_sync[4]);
            end else begin
                s_d.a_level = stc_step(s_q.a_level, pins_sync[4]);
            end
        end

        // Delayed sweep arming
        if (hw_a_fired) begin
            s_d.b_progress_a = 1'b1;
        end else if (hw_saved) begin
            s_d.b_progress_a = 1'b0;
        end

        case (s_q.al_state)
            STC_AL_IDLE: begin
            end
            STC_AL_MEASURE: begin
                if ($signed(sig_level) < $signed(s_q.sig_min)) begin
                    s_d.sig_min = sig_level;
                end
                if ($signed(sig_level) > $signed(s_q.sig_max)) begin
                    s_d.sig_max = sig_level;
                end
                s_d.al_cnt = s_q.al_cnt - 1'b1;
                if (s_q.al_cnt == 8'h01) begin
                    s_d.al_state = STC_AL_DONE;
                end
            end
            STC_AL_DONE: begin
                s_d.a_level = stc_mid(s_q.sig_max, s_q.sig_min);
                s_d.minmax_valid = 1'b1;
                s_d.al_state = STC_AL_IDLE;
            end
            default: begin
                s_d.al_state = STC_AL_IDLE;
            end
        endcase

        // Events from the line-range check
        maxline = pins_sync[3] && s_q.interlaced_field_choice == STC_FLD_ALT ?
                  `STC_VIDEO_LINE_NUMBER_MAX_F2 : `STC_VIDEO_LINE_NUMBER_MAX_F1;

        if (wr) begin
            s_d.minmax_valid = 1'b0;
            case (addr)
                `STC_ADDR_CMD: begin
                    if (wdata[`STC_CMD_CLR_BIT]) begin
                        s_d.progress = STC_PROG_PROGRESS_A;
                    end
                    if (wdata[`STC_CMD_AUTOLVL_BIT]) begin
                        s_d.al_state = STC_AL_MEASURE;
                        s_d.al_cnt = 8'(`STC_AUTOLVL_CYC);
                        s_d.sig_min = sig_level;
                        s_d.sig_max = sig_level;
                    end
                    if (wdata[`STC_CMD_ASEC_BIT]) begin
                        s_d.holdoff = `STC_HOLDOFF_RST;
                    end
                end
                `STC_ADDR_HOLDOFF: begin
                    if (wdata[31]) begin
                        s_d.holdoff = '0;
                        s_d.warn_flag = s_q.warn_en | s_q.warn_flag;
                    end else if (|wdata[30:`STC_HOLDOFF_W]
                                 || wdata[`STC_HOLDOFF_W-1:0] > `STC_HOLDOFF_MAX) begin
                        s_d.holdoff = `STC_HOLDOFF_MAX;
                        s_d.warn_flag = s_q.warn_en | s_q.warn_flag;
                    end else begin
                        s_d.holdoff = wdata[`STC_HOLDOFF_W-1:0];
                    end
                end
                `STC_ADDR_PROGRESS_A_FIRED: begin
                    s_d.a_level = wdata[`STC_LVL_W-1:0];
                    s_d.knob_b = wdata[16];
                end
                `STC_ADDR_BTRIG: begin
                    s_d.trig_after = wdata[0];
                    s_d.ext_clk = wdata[1];
                    s_d.b_slope = wdata[2];
                    s_d.b_position = (wdata[12:8] == 5'h00) ? 5'h01 :
                                     (wdata[12:8] > 5'h1E) ? 5'h1E : wdata[12:8];
                    if (wdata[6:4] != 3'h2 || word_probe_present) begin
                        s_d.b_source = wdata[6:4];
                    end else begin
                        s_d.warn_flag = s_q.warn_en | s_q.warn_flag;
                    end
                    if (wdata[18:16] < 3'h5) begin
                        s_d.b_coupling = wdata[18:16];
                    end else begin
                        s_d.err_flag = s_q.err_en | s_q.err_flag;
                    end
                end
                `STC_ADDR_BLEVEL: begin
                    s_d.b_level = wdata[`STC_LVL_W-1:0];
                end
                `STC_ADDR_TV, `STC_ADDR_VIDEO_LINE_NUMBER: begin
                    if (!video_option_present) begin
                        s_d.err_flag = s_q.err_en | s_q.err_flag;
                    end else if (addr == `STC_ADDR_VIDEO_LINE_NUMBER) begin
                        s_d.video_line_number = wdata[`STC_VIDEO_LINE_NUMBER_W-1:0];
                    end else begin
                        s_d.interlaced_field_choice = stc_field_t'(wdata[1:0]);
                        s_d.nic_line = wdata[2];
                        s_d.clamp = wdata[3];
                        s_d.lcnt_reset_first_field_only = wdata[4];
                        s_d.lcnt_start_before_field_sync = wdata[5];
                        s_d.sync_pos = wdata[6];
                        s_d.tv_selected = wdata[7];
                        if (wdata[7] && !s_q.tv_selected
                            && (s_q.video_line_number == '0 || s_q.video_line_number > maxline)) begin
                            s_d.warn_flag = s_q.warn_en | s_q.warn_flag;
                        end
                    end
                end
                `STC_ADDR_EVENTS: begin
                    s_d.warn_en = wdata[0];
                    s_d.err_en = wdata[1];
                    if (wdata[8]) begin
                        s_d.warn_flag = 1'b0;
                    end
                    if (wdata[9]) begin
                        s_d.err_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data is registered and stands for one cycle
        if (rd) begin
            case (addr)
                `STC_ADDR_HOLDOFF: s_d.rdata = 32'(s_q.holdoff);
                `STC_ADDR_PROGRESS_A_FIRED: s_d.rdata = {15'h0000, s_q.knob_b, 4'h0, s_q.a_level};
                `STC_ADDR_BTRIG: s_d.rdata = {13'h0000, s_q.b_coupling, 3'h0, s_q.b_position,
                                              1'b0, s_q.b_source, 1'b0, s_q.b_slope,
                                              s_q.ext_clk, s_q.trig_after};
                `STC_ADDR_BLEVEL: s_d.rdata = 32'(s_q.b_level);
                `STC_ADDR_TV: s_d.rdata = {24'h000000, s_q.tv_selected, s_q.sync_pos,
                                           s_q.lcnt_start_before_field_sync, s_q.lcnt_reset_first_field_only, s_q.clamp,
                                           s_q.nic_line, s_q.interlaced_field_choice};
                `STC_ADDR_VIDEO_LINE_NUMBER: s_d.rdata = 32'(s_q.video_line_number);
                `STC_ADDR_STATUS: s_d.rdata = {23'h000000, s_q.minmax_valid,
                                               s_q.al_state != STC_AL_IDLE,
                                               pins_sync[3],
                                               s_q.knob_b, 2'h0, s_q.progress};
                `STC_ADDR_MINMAX: s_d.rdata = {4'h0, s_q.sig_max, 4'h0, s_q.sig_min};
                `STC_ADDR_EVENTS: s_d.rdata = {22'h000000, s_q.err_flag, s_q.warn_flag,
                                               6'h00, s_q.err_en, s_q.warn_en};
                default: s_d.rdata = '0;
            endcase
        end

        // Events are raised only by writes to other registers, so a clear never meets a new event in the same cycle
    end

    // Line, position, coupling and mode leave reset at nonzero defaults
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.video_line_number <= `STC_VIDEO_LINE_NUMBER_RST;
            s_q.b_position <= 5'h10;
            s_q.b_coupling <= 3'h1;
            s_q.trig_after <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign holdoff_setting = s_q.holdoff;
    assign main_level = (s_q.clamp && s_q.tv_selected) ? '0 : s_q.a_level;
    assign delayed_level = s_q.b_level;
    assign status_show_delayed = s_q.knob_b;
    assign triggered_after_main = s_q.trig_after;
    assign b_sweep_go = s_q.b_progress_a & (~s_q.trig_after | pins_sync[0]);
    assign external_sample_clock = s_q.ext_clk;
    assign sample_strobe = s_q.ext_clk & pins_sync[0] & ~s_q.b_clk_q;
    assign back_porch_clamp = s_q.clamp;
    assign video_line_trigger = line_hit &
        (pins_sync[3] || s_q.interlaced_field_choice == STC_FLD_ONE || !s_q.nic_line);
    assign service_request = s_q.warn_flag | s_q.err_flag;
    assign srq_cause = {s_q.err_flag, s_q.warn_flag};
endmodule : stc_top

// ==== testbench/stc_host.sv ====
`timescale 1ns/1ps
module stc_host (
    input wire logic clk,
    output logic [3:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [31:0] rdata
);
    initial begin
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Idle bus shows inverted values, never the last request
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : rd_reg
endmodule : stc_host

// ==== testbench/stc_top_props.sv ====
`timescale 1ns/1ps
module stc_top_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic video_option_present,
    input wire logic [10:0] holdoff_setting,
    input wire logic status_show_delayed,
    input wire logic triggered_after_main,
    input wire logic external_sample_clock,
    input wire logic sample_strobe,
    input wire logic back_porch_clamp,
    input wire logic video_line_trigger,
    input wire logic service_request,
    input wire logic [1:0] srq_cause
);
    logic ho_wr;
    logic tv_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    assign ho_wr = wr && addr == 4'h1;
    assign tv_wr = wr && addr == 4'h5;
    holdoff_limit_a: assert property (holdoff_setting <= 11'h640)
        else $error("holdoff above ceiling");
    holdoff_exact_a: assert property (ho_wr && !wdata[31] && wdata <= 32'h640
        |=> holdoff_setting == $past(wdata[10:0])) else $error("holdoff not stored");
    holdoff_clamp_a: assert property (ho_wr && !wdata[31] && wdata > 32'h640
        |=> holdoff_setting == 11'h640) else $error("holdoff not clamped high");
    holdoff_neg_a: assert property (ho_wr && wdata[31] |=> holdoff_setting == 11'h000)
        else $error("holdoff not clamped low");
    holdoff_asec_a: assert property (wr && addr == 4'h0 && wdata[2]
        |=> holdoff_setting == 11'h000) else $error("holdoff kept on time base change");
    knob_select_a: assert property (wr && addr == 4'h2
        |=> status_show_delayed == $past(wdata[16])) else $error("knob select wrong");
    b_mode_a: assert property (wr && addr == 4'h3 |=> triggered_after_main == $past(wdata[0])
        && external_sample_clock == $past(wdata[1])) else $error("delayed mode wrong");
    strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe too long");
    srq_level_a: assert property (service_request == (srq_cause != 2'h0))
        else $error("service request disagrees with cause");
    video_refuse_a: assert property (tv_wr && !video_option_present
        |=> $stable(back_porch_clamp)) else $error("video write taken without option");
    clamp_set_a: assert property (tv_wr && video_option_present
        |=> back_porch_clamp == $past(wdata[3])) else $error("clamp not set");
    line_pulse_a: assert property (video_line_trigger |=> !video_line_trigger)
        else $error("line trigger too long");
    cover property (ho_wr && wdata > 32'h640);
    cover property (sample_strobe);
    cover property (tv_wr && !video_option_present);
endmodule : stc_top_props

bind stc_top stc_top_props chk_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .video_option_present(video_option_present), .holdoff_setting(holdoff_setting),
    .status_show_delayed(status_show_delayed), .triggered_after_main(triggered_after_main),
    .external_sample_clock(external_sample_clock), .sample_strobe(sample_strobe),
    .back_porch_clamp(back_porch_clamp), .video_line_trigger(video_line_trigger),
    .service_request(service_request), .srq_cause(srq_cause));

// ==== testbench/stc_top_tb.sv ====
`timescale 1ns/1ps
module stc_top_tb;
    logic clk, rst_b, wr, rd, knob_step, knob_up, vopt, vint, vsync, vfs, vf2, btrig;
    logic [3:0] addr, ev;
    logic [31:0] wdata, rdata;
    logic [11:0] sig_level, main_level, delayed_level;
    logic [10:0] holdoff;
    logic show_b, trig_after, b_go, ext_clk, strobe, clamp, line_trig, srq;
    logic [1:0] cause;
    logic [6:0] vcnt;
    int err_count, check_count, strobes, lines, n0;
    stc_host host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    stc_top dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .hw_ready(ev[0]), .hw_a_fired(ev[1]), .hw_b_fired(ev[2]),
        .hw_saved(ev[3]), .sig_level(sig_level), .knob_step(knob_step), .knob_up(knob_up),
        .video_option_present(vopt), .word_probe_present(1'b0), .video_interlaced(vint),
        .video_sync(vsync), .video_field_sync(vfs), .video_field_two(vf2),
        .b_trigger_in(btrig), .holdoff_setting(holdoff), .main_level(main_level),
        .delayed_level(delayed_level), .status_show_delayed(show_b),
        .triggered_after_main(trig_after), .b_sweep_go(b_go), .external_sample_clock(ext_clk),
        .sample_strobe(strobe), .back_porch_clamp(clamp), .video_line_trigger(line_trig),
        .service_request(srq), .srq_cause(cause));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Signal swings between two levels; video timing runs free
    always @(posedge clk) begin
        sig_level <= (sig_level == 12'h0C0) ? 12'h040 : 12'h0C0;
        vcnt <= vcnt + 7'h01;
        vsync <= vcnt[1];
        vfs <= vcnt[5:2] == 4'h0;
        vf2 <= vcnt[6];
        if (strobe === 1'b1)
            strobes++;
        if (line_trig === 1'b1)
            lines++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host_u.rd_reg(a, d);
        chk(d, exp);
    endtask : rchk
    task automatic ev_pulse(input logic [3:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 4'h0;
    endtask : ev_pulse
    task automatic b_pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            btrig <= 1'b1;
            repeat (2) @(posedge clk);
            btrig <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        #1;
    endtask : b_pulses
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        {rst_b, knob_step, knob_up, vopt, vint, btrig, ev, vcnt} = '0;
        sig_level = 12'h040;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rchk(4'h1, 32'h0);
        rchk(4'h6, 32'h1);
        rchk(4'h7, 32'h0);
        host_u.wr_reg(4'h9, 32'h3);
        host_u.wr_reg(4'h1, 32'h20);
        chk(32'(holdoff), 32'h20);
        host_u.wr_reg(4'h1, 32'h641);
        chk(32'(holdoff), 32'h640);
        chk({29'h0, srq, cause}, 32'h5);
        host_u.wr_reg(4'h9, 32'h103);
        host_u.wr_reg(4'h1, 32'hFFFF_FFF0);
        chk(32'(holdoff), 32'h0);
        host_u.wr_reg(4'h1, 32'h100);
        host_u.wr_reg(4'h0, 32'h4);
        chk(32'(holdoff), 32'h0);
        host_u.wr_reg(4'h9, 32'h103);
        host_u.wr_reg(4'h2, 32'h1_0000);
        chk(32'(show_b), 32'h1);
        @(posedge clk);
        {knob_up, knob_step} <= 2'b11;
        @(posedge clk);
        knob_step <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(32'(delayed_level), 32'h1);
        chk(32'(main_level), 32'h0);
        ev_pulse(4'h2);
        ev_pulse(4'h1);
        rchk(4'h7, 32'h22);
        ev_pulse(4'h8);
        rchk(4'h7, 32'h24);
        host_u.wr_reg(4'h0, 32'h1);
        rchk(4'h7, 32'h20);
        ev_pulse(4'h4);
        rchk(4'h7, 32'h23);
        host_u.wr_reg(4'h0, 32'h2);
        repeat (25) @(posedge clk);
        #1;
        chk(32'(main_level), 32'h80);
        rchk(4'h7, 32'h123);
        rchk(4'h8, 32'h00C0_0040);
        host_u.wr_reg(4'h9, 32'h3);
        rchk(4'h7, 32'h23);
        host_u.wr_reg(4'h3, 32'h0001_1002);
        chk({30'h0, ext_clk, trig_after}, 32'h2);
        b_pulses(3);
        chk(32'(strobes), 32'h3);
        host_u.wr_reg(4'h3, 32'h0001_1001);
        b_pulses(1);
        chk(32'(strobes), 32'h3);
        ev_pulse(4'h2);
        #1;
        chk(32'(b_go), 32'h0);
        host_u.wr_reg(4'h3, 32'h0001_1020);
        chk(32'(b_go), 32'h1);
        chk(32'(cause), 32'h1);
        rchk(4'h3, 32'h0001_1000);
        host_u.wr_reg(4'h9, 32'h103);
        host_u.wr_reg(4'h5, 32'h88);
        chk({30'h0, clamp, 1'b0}, 32'h0);
        chk(32'(cause), 32'h2);
        host_u.wr_reg(4'h9, 32'h203);
        @(posedge clk) vopt <= 1'b1;
        host_u.wr_reg(4'h6, 32'h0);
        host_u.wr_reg(4'h5, 32'h88);
        chk(32'(clamp), 32'h1);
        chk(32'(main_level), 32'h0);
        chk(32'(cause), 32'h1);
        @(posedge clk) vint <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(4'h7, 32'h63);
        host_u.wr_reg(4'h6, 32'h5);
        // One hit per frame where line 5 lies in the chosen field
        for (int m = 0; m < 4; m++) begin
            host_u.wr_reg(4'h5, 32'h80 | (m * 32'h31));
            repeat (130) @(posedge clk);
            #1;
            n0 = lines;
            repeat (256) @(posedge clk);
            #1;
            chk(32'(lines - n0), (m % 2 == 0) ? 32'h2 : 32'h0);
        end
        wrap_up();
    end
endmodule : stc_top_tb
